//--- design/mmuf_front.v
// Behaviour
// [RULE_01] control holds mmu, alignment, protection bits
// [RULE_02] one table base, bits 31:14, shared
// [RULE_03] domain control: sixteen two-bit fields
// [RULE_04] fault status records domain and type
// [RULE_05] fault address captures full virtual address
// [RULE_06] data abort updates status and address
// [RULE_07] maintenance write invalidates all or one
// [RULE_08] maintenance register is write only
// [RULE_09] other registers readable and writable
// [RULE_10] separate lockdown per tlb, subcode selects
// [RULE_11] walk only on tlb miss
// [RULE_12] table base reads zero low 14 bits
// [RULE_13] table covers 4096 one-megabyte entries
// [RULE_14] descriptor address is base plus va
// [RULE_15] each fetch reads one word entry
// [RULE_16] sections end after level one fetch
// [RULE_17] translate addresses, check using tlb entries
// [RULE_18] fetch byte address ends in two zeros
// [RULE_19] decode descriptor type from low bits
// [RULE_20] victim counter wraps from 63 to base
// [RULE_21] preserved entries survive invalidate all
// [RULE_22] each tlb holds 64 entries
`timescale 1ns/100ps
`include "mmuf_consts.vh"
module mmuf_front #(
  parameter ENTRIES = `MMUF_TLB_ENTRIES
) (
  input wire clk,
  input wire reset,
  input wire cp_wr,
  input wire cp_rd,
  input wire [3:0] cp_reg,
  input wire [2:0] cp_sub,
  input wire [31:0] cp_wdata,
  output reg [31:0] cp_rdata_r,
  output reg cp_rvalid_r,
  input wire acc_req,
  input wire acc_instr,
  input wire [31:0] acc_va,
  input wire [1:0] acc_size,
  output reg acc_done_r,
  output reg acc_abort_r,
  output reg [31:0] acc_pa_r,
  output reg mem_req_r,
  output reg [31:0] mem_addr_r,
  input wire mem_ack,
  input wire [31:0] mem_rdata,
  output reg walk_l2_r,
  output reg [31:0] walk_desc_r
);
  localparam ST_IDLE = 5'b00001;
  localparam ST_LOOK = 5'b00010;
  localparam ST_DEC = 5'b00100;
  localparam ST_FETCH = 5'b01000;
  localparam ST_DONE = 5'b10000;

  reg [31:0] ctrl_r;
  reg [17:0] ttb_r;
  reg [31:0] dac_r;
  reg [7:0] fsr_r;
  reg [31:0] far_r;
  reg [5:0] dbase_r, dvict_r, ibase_r, ivict_r;
  reg dpres_r, ipres_r;
  reg [4:0] st_r;
  reg [31:0] va_r;
  reg instr_r;
  reg [1:0] size_r;
  reg stale_r;
  wire dhit, ihit;
  wire [11:0] dsect_pa;
  wire [11:0] isect_pa;
  wire inv_all = cp_wr && cp_reg == `MMUF_REG_TLBOP && cp_sub == `MMUF_OP_INV_ALL; // [RULE_07]
  wire inv_one = cp_wr && cp_reg == `MMUF_REG_TLBOP && cp_sub == `MMUF_OP_INV_ONE; // [RULE_07]
  // only sections are cached: a page entry needs the level-two result first
  wire refill = st_r == ST_FETCH && mem_ack && mem_rdata[1:0] == `MMUF_DESC_SECTION;
  wire [11:0] look_tag = inv_one ? cp_wdata[31:20] : va_r[31:20];
  wire misalign = ctrl_r[`MMUF_CTRL_A] && !instr_r &&
    ((size_r == 2'h1 && va_r[0]) || (size_r == 2'h2 && va_r[1:0] != 2'h0));

  // next victim: wrap from last entry to lockdown base
  function [5:0] next_victim;
    input [5:0] cur;
    input [5:0] base;
    begin
      next_victim = (cur == `MMUF_TLB_LAST) ? base : cur + 6'h01; // [RULE_20]
    end
  endfunction

  // lockdown copy addressed by register number and select subcode
  function lock_sel;
    input [3:0] num;
    input [2:0] sub;
    input [2:0] want;
    begin
      lock_sel = num == `MMUF_REG_LOCK && sub == want; // [RULE_10]
    end
  endfunction

  // one tag store per tlb, 64 entries each
  mmuf_tag_mem #(.DEPTH(ENTRIES), .AW(6)) u_dtlb ( // [RULE_22]
    .clk(clk),
    .reset(reset),
    .wr_en(refill && !instr_r),
    .wr_idx(dvict_r),
    .wr_tag(va_r[31:20]),
    .wr_pres(dpres_r),
    .wr_base(mem_rdata[31:20]),
    .inv_all(inv_all), // [RULE_21]
    .inv_one(inv_one),
    .look_tag(look_tag),
    .hit_r(dhit),
    .hit_base_r(dsect_pa)
  );
  mmuf_tag_mem #(.DEPTH(ENTRIES), .AW(6)) u_itlb (
    .clk(clk),
    .reset(reset),
    .wr_en(refill && instr_r),
    .wr_idx(ivict_r),
    .wr_tag(va_r[31:20]),
    .wr_pres(ipres_r),
    .wr_base(mem_rdata[31:20]),
    .inv_all(inv_all),
    .inv_one(inv_one),
    .look_tag(look_tag),
    .hit_r(ihit),
    .hit_base_r(isect_pa)
  );

  // register reads; maintenance register returns zero
  always @(posedge clk) begin
    if (reset) begin
      cp_rdata_r <= 32'h0000_0000;
      cp_rvalid_r <= 1'b0;
    end else begin
      cp_rvalid_r <= cp_rd;
      if (cp_reg == `MMUF_REG_CTRL) begin
        cp_rdata_r <= ctrl_r; // [RULE_09]
      end else if (cp_reg == `MMUF_REG_TTB) begin
        cp_rdata_r <= {ttb_r, 14'h0000}; // [RULE_12]
      end else if (cp_reg == `MMUF_REG_DAC) begin
        cp_rdata_r <= dac_r; // [RULE_03]
      end else if (cp_reg == `MMUF_REG_FSR) begin
        cp_rdata_r <= {24'h00_0000, fsr_r};
      end else if (cp_reg == `MMUF_REG_FAR) begin
        cp_rdata_r <= far_r;
      end else if (lock_sel(cp_reg, cp_sub, `MMUF_SEL_INSTR)) begin
        cp_rdata_r <= {ibase_r, ivict_r, 19'h0_0000, ipres_r}; // [RULE_10]
      end else if (lock_sel(cp_reg, cp_sub, `MMUF_SEL_DATA)) begin
        cp_rdata_r <= {dbase_r, dvict_r, 19'h0_0000, dpres_r};
      end else begin
        cp_rdata_r <= 32'h0000_0000; // [RULE_08]
      end
    end
  end

  // register writes; hardware fault capture wins over software
  always @(posedge clk) begin
    if (reset) begin
      ctrl_r <= 32'h0000_0000;
      ttb_r <= 18'h0_0000;
      dac_r <= 32'h0000_0000;
      fsr_r <= 8'h00;
      far_r <= 32'h0000_0000;
      dbase_r <= 6'h00;
      dvict_r <= 6'h00;
      dpres_r <= 1'b0;
      ibase_r <= 6'h00;
      ivict_r <= 6'h00;
      ipres_r <= 1'b0;
    end else begin
      if (cp_wr && cp_reg == `MMUF_REG_CTRL) begin
        ctrl_r <= cp_wdata; // [RULE_01]
      end
      if (cp_wr && cp_reg == `MMUF_REG_TTB) begin
        ttb_r <= cp_wdata[31:14]; // [RULE_02]
      end
      if (cp_wr && cp_reg == `MMUF_REG_DAC) begin
        dac_r <= cp_wdata;
      end
      if (cp_wr && cp_reg == `MMUF_REG_FSR) begin
        fsr_r <= cp_wdata[7:0];
      end
      if (cp_wr && cp_reg == `MMUF_REG_FAR) begin
        far_r <= cp_wdata;
      end
      // victim advances on each refill of its tlb
      if (refill && !instr_r) begin
        dvict_r <= next_victim(dvict_r, dbase_r); // [RULE_20]
      end
      if (refill && instr_r) begin
        ivict_r <= next_victim(ivict_r, ibase_r);
      end
      if (cp_wr && lock_sel(cp_reg, cp_sub, `MMUF_SEL_DATA)) begin
        dbase_r <= cp_wdata[31:26];
        dvict_r <= cp_wdata[25:20];
        dpres_r <= cp_wdata[0];
      end
      if (cp_wr && lock_sel(cp_reg, cp_sub, `MMUF_SEL_INSTR)) begin
        ibase_r <= cp_wdata[31:26];
        ivict_r <= cp_wdata[25:20];
        ipres_r <= cp_wdata[0];
      end
      // abort capture: domain from descriptor on section fault, zero on alignment fault; type code low
      if (st_r == ST_LOOK && misalign) begin
        fsr_r <= {4'h0, `MMUF_FT_ALIGN}; // [RULE_04]
        far_r <= va_r; // [RULE_05] [RULE_06]
      end else if (st_r == ST_FETCH && mem_ack && mem_rdata[1:0] == `MMUF_DESC_INVALID) begin
        fsr_r <= {mem_rdata[8:5], `MMUF_FT_SECT}; // [RULE_04]
        if (!instr_r) begin
          far_r <= va_r; // [RULE_06]
        end
      end
    end
  end

  // maintenance in the lookup cycle borrows or changes the tag compare,
  // so the hit latched then cannot be trusted
  always @(posedge clk) begin
    if (reset) begin
      stale_r <= 1'b0;
    end else begin
      stale_r <= (inv_all || inv_one) && st_r == ST_LOOK;
    end
  end

  // access sequencer: lookup, then walk on miss
  always @(posedge clk) begin
    if (reset) begin
      st_r <= ST_IDLE;
      va_r <= 32'h0000_0000;
      instr_r <= 1'b0;
      size_r <= 2'h0;
      acc_done_r <= 1'b0;
      acc_abort_r <= 1'b0;
      acc_pa_r <= 32'h0000_0000;
      mem_req_r <= 1'b0;
      mem_addr_r <= 32'h0000_0000;
      walk_l2_r <= 1'b0;
      walk_desc_r <= 32'h0000_0000;
    end else begin
      acc_done_r <= 1'b0;
      acc_abort_r <= 1'b0;
      walk_l2_r <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (acc_req) begin
            va_r <= acc_va;
            instr_r <= acc_instr;
            size_r <= acc_size;
            st_r <= ST_LOOK;
          end
        end
        ST_LOOK: begin
          // wait one cycle for the registered hit
          st_r <= ST_DEC;
          if (misalign) begin
            acc_abort_r <= 1'b1; // [RULE_01]
            acc_done_r <= 1'b1;
            st_r <= ST_IDLE;
          end else if (!ctrl_r[`MMUF_CTRL_M]) begin
            acc_pa_r <= va_r; // flat mapping when disabled
            acc_done_r <= 1'b1;
            st_r <= ST_IDLE;
          end
        end
        ST_DEC: begin
          if (stale_r) begin
            st_r <= ST_LOOK; // maintenance borrowed or changed the tag compare, look again
          end else if (instr_r ? ihit : dhit) begin
            acc_pa_r <= {instr_r ? isect_pa : dsect_pa, va_r[19:0]}; // [RULE_17]
            acc_done_r <= 1'b1;
            st_r <= ST_IDLE;
          end else begin
            // 4096-entry table indexed by va[31:20]
            mem_addr_r <= {ttb_r, va_r[31:20], 2'b00}; // [RULE_11] [RULE_13] [RULE_14] [RULE_18]
            mem_req_r <= 1'b1; // [RULE_15]
            st_r <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (mem_ack) begin
            mem_req_r <= 1'b0;
            walk_desc_r <= mem_rdata;
            st_r <= ST_DONE;
            if (mem_rdata[1:0] == `MMUF_DESC_SECTION) begin
              acc_pa_r <= {mem_rdata[31:20], va_r[19:0]}; // [RULE_16]
              acc_done_r <= 1'b1;
            end else if (mem_rdata[1:0] == `MMUF_DESC_INVALID) begin
              acc_abort_r <= 1'b1; // [RULE_19]
              acc_done_r <= 1'b1;
            end else begin
              walk_l2_r <= 1'b1; // coarse or fine: second level needed
            end
          end
        end
        ST_DONE: begin
          st_r <= ST_IDLE;
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

//--- design/mmuf_consts.vh
`ifndef MMUF_CONSTS_VH
`define MMUF_CONSTS_VH
// coprocessor register numbers
`define MMUF_REG_CTRL 4'h1
`define MMUF_REG_TTB 4'h2
`define MMUF_REG_DAC 4'h3
`define MMUF_REG_FSR 4'h5
`define MMUF_REG_FAR 4'h6
`define MMUF_REG_TLBOP 4'h8
`define MMUF_REG_LOCK 4'ha
// lockdown select subcode
`define MMUF_SEL_DATA 3'h0
`define MMUF_SEL_INSTR 3'h1
// control register bit positions
`define MMUF_CTRL_M 0
`define MMUF_CTRL_A 1
`define MMUF_CTRL_S 8
`define MMUF_CTRL_R 9
// maintenance subcodes
`define MMUF_OP_INV_ALL 3'h0
`define MMUF_OP_INV_ONE 3'h1
// fault type codes
`define MMUF_FT_ALIGN 4'h1
`define MMUF_FT_SECT 4'h5
// descriptor type codes
`define MMUF_DESC_INVALID 2'h0
`define MMUF_DESC_COARSE 2'h1
`define MMUF_DESC_SECTION 2'h2
`define MMUF_DESC_FINE 2'h3
// entries per tlb and last index
`define MMUF_TLB_ENTRIES 64
`define MMUF_TLB_LAST 6'h3f
`endif

//--- design/mmuf_tag_mem.v
`timescale 1ns/100ps
// one tlb: 64 tags (va[31:20]) with section bases, valid and preserve flags, registered hit
module mmuf_tag_mem #(
  parameter DEPTH = 64,
  parameter AW = 6
) (
  input wire clk,
  input wire reset,
  input wire wr_en,
  input wire [AW-1:0] wr_idx,
  input wire [11:0] wr_tag,
  input wire wr_pres,
  input wire inv_all,
  input wire inv_one,
  input wire [11:0] look_tag,
  input wire [11:0] wr_base,
  output reg hit_r,
  output reg [11:0] hit_base_r
);
  reg [11:0] tag_r [0:DEPTH-1];
  reg [11:0] base_r [0:DEPTH-1];
  reg [DEPTH-1:0] val_r;
  reg [DEPTH-1:0] pres_r;
  reg hit_nxt;
  reg [11:0] hit_base_nxt;
  integer i;
  integer j;

  // associative compare over all entries; only a miss loads, so a tag sits once
  always @* begin
    hit_nxt = 1'b0;
    hit_base_nxt = 12'h000;
    for (i = 0; i < DEPTH; i = i + 1) begin
      if (val_r[i] && tag_r[i] == look_tag) begin
        hit_nxt = 1'b1;
        hit_base_nxt = base_r[i];
      end
    end
  end

  // refill and invalidation; refill wins on the same entry
  always @(posedge clk) begin
    if (reset) begin
      val_r <= {DEPTH{1'b0}};
      pres_r <= {DEPTH{1'b0}};
      hit_r <= 1'b0;
      hit_base_r <= 12'h000;
    end else begin
      hit_r <= hit_nxt;
      hit_base_r <= hit_base_nxt;
      for (j = 0; j < DEPTH; j = j + 1) begin
        if (inv_all && !pres_r[j]) begin
          val_r[j] <= 1'b0; // preserved entries survive
        end
        if (inv_one && val_r[j] && tag_r[j] == look_tag) begin
          val_r[j] <= 1'b0;
        end
      end
      if (wr_en) begin
        tag_r[wr_idx] <= wr_tag;
        base_r[wr_idx] <= wr_base;
        val_r[wr_idx] <= 1'b1;
        pres_r[wr_idx] <= wr_pres;
      end
    end
  end
endmodule

//--- testbench/mmuf_mem_model.sv
`timescale 1ns/100ps
// memory side of the level-one fetch, answering after dly cycles
module mmuf_mem_model (
  input wire clk,
  input wire reset,
  input wire mem_req_r,
  input wire [1:0] dly,
  input wire [31:0] desc,
  output reg mem_ack,
  output reg [31:0] mem_rdata
);
  reg [1:0] wait_r;
  // data toggles outside the ack cycle so a stale word never looks valid
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (reset) begin
      wait_r <= 2'h0;
      mem_rdata <= 32'h0000_0000;
    end else if (mem_req_r && !mem_ack) begin
      if (wait_r == dly) begin
        mem_ack <= 1'b1;
        mem_rdata <= desc; // one word per fetch
        wait_r <= 2'h0;
      end else begin
        wait_r <= wait_r + 2'h1;
      end
    end
  end
endmodule

//--- testbench/mmuf_front_monitor.sv
`timescale 1ns/100ps
module mmuf_front_chk #(
  parameter ENTRIES = 64
) (
  input wire clk,
  input wire reset,
  input wire cp_rd,
  input wire [3:0] cp_reg,
  input wire [31:0] cp_rdata_r,
  input wire cp_rvalid_r,
  input wire acc_done_r,
  input wire acc_abort_r,
  input wire mem_req_r,
  input wire [31:0] mem_addr_r,
  input wire mem_ack,
  input wire [31:0] mem_rdata,
  input wire walk_l2_r
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // register side
  rd_answer_a: assert property (cp_rd |=> cp_rvalid_r)
    else $error("read not answered");
  tlbop_zero_a: assert property (cp_rd && cp_reg == 4'h8 |=> cp_rdata_r == 32'h0000_0000)
    else $error("maintenance read not zero");
  base_low_a: assert property (cp_rd && cp_reg == 4'h2 |=> cp_rdata_r[13:0] == 14'h0000)
    else $error("table base low bits set");
  fsr_high_a: assert property (cp_rd && cp_reg == 4'h5 |=> cp_rdata_r[31:8] == 24'h00_0000)
    else $error("fault status upper bits set");
  // fetch side, partner acks only while a request stands
  fetch_align_a: assert property ($rose(mem_req_r) |-> mem_addr_r[1:0] == 2'h0)
    else $error("fetch not word aligned");
  fetch_hold_a: assert property (mem_req_r && !mem_ack |=> mem_req_r && $stable(mem_addr_r))
    else $error("fetch dropped early");
  fetch_once_a: assert property (mem_req_r && mem_ack |=> !mem_req_r)
    else $error("fetch repeated");
  section_done_a: assert property (mem_req_r && mem_ack && mem_rdata[1:0] == 2'h2
    |=> acc_done_r && !acc_abort_r && !walk_l2_r) else $error("section not finished");
  invalid_abort_a: assert property (mem_req_r && mem_ack && mem_rdata[1:0] == 2'h0
    |=> acc_abort_r && !walk_l2_r) else $error("invalid descriptor not aborted");
  level_two_a: assert property (mem_req_r && mem_ack && mem_rdata[0]
    |=> walk_l2_r && !acc_abort_r) else $error("page table not handed on");
  cover property (mem_req_r && mem_ack && mem_rdata[1:0] == 2'h2);
  cover property (acc_abort_r);
  cover property (walk_l2_r);
endmodule
bind mmuf_front mmuf_front_chk #(.ENTRIES(ENTRIES)) u_chk (.clk(clk), .reset(reset),
  .cp_rd(cp_rd), .cp_reg(cp_reg), .cp_rdata_r(cp_rdata_r), .cp_rvalid_r(cp_rvalid_r),
  .acc_done_r(acc_done_r), .acc_abort_r(acc_abort_r), .mem_req_r(mem_req_r),
  .mem_addr_r(mem_addr_r), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .walk_l2_r(walk_l2_r));

//--- testbench/mmuf_front_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin checks = checks + 1; if ((a) !== (b)) begin \
  mismatches = mismatches + 1; $display("wrong value at %0t: %h", $time, a); end end
module mmuf_front_tb;
  reg clk = 0, reset = 1, cp_wr = 0, cp_rd = 0, acc_req = 0, acc_instr = 0;
  reg [3:0] cp_reg = 0;
  reg [2:0] cp_sub = 0;
  reg [1:0] acc_size = 2, dly = 0;
  reg [31:0] cp_wdata = 0, acc_va = 0, desc = 0, got, addr, wd, va, dsc, translation_table_base;
  reg [31:0] wr_val [0:7];
  wire [31:0] cp_rdata_r, acc_pa_r, mem_addr_r, mem_rdata, walk_desc_r;
  wire cp_rvalid_r, acc_done_r, acc_abort_r, mem_req_r, mem_ack, walk_l2_r;
  integer mismatches = 0, checks = 0, i, kind, fetched;
  always #2.5 clk = ~clk;
  mmuf_front dut (.clk(clk), .reset(reset), .cp_wr(cp_wr), .cp_rd(cp_rd), .cp_reg(cp_reg),
    .cp_sub(cp_sub), .cp_wdata(cp_wdata), .cp_rdata_r(cp_rdata_r), .cp_rvalid_r(cp_rvalid_r),
    .acc_req(acc_req), .acc_instr(acc_instr), .acc_va(acc_va), .acc_size(acc_size),
    .acc_done_r(acc_done_r), .acc_abort_r(acc_abort_r), .acc_pa_r(acc_pa_r),
    .mem_req_r(mem_req_r), .mem_addr_r(mem_addr_r), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .walk_l2_r(walk_l2_r), .walk_desc_r(walk_desc_r));
  mmuf_mem_model u_mem (.clk(clk), .reset(reset), .mem_req_r(mem_req_r), .dly(dly),
    .desc(desc), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  task cp_write(input [3:0] r, input [2:0] s, input [31:0] d);
    begin
      @(negedge clk);
      {cp_wr, cp_reg, cp_sub, cp_wdata} = {1'b1, r, s, d};
      @(negedge clk);
      cp_wr = 0;
    end
  endtask
  task cp_read(input [3:0] r, input [2:0] s);
    begin
      @(negedge clk);
      {cp_rd, cp_reg, cp_sub} = {1'b1, r, s};
      @(negedge clk);
      cp_rd = 0;
      `CHK(cp_rvalid_r, 1'b1)
      got = cp_rdata_r;
    end
  endtask
  // kind: 0 done, 1 abort, 2 level two; bounded wait
  task access(input ins, input [31:0] v, input [31:0] d, input [1:0] sz);
    integer n;
    begin
      desc = d;
      dly = $urandom;
      @(negedge clk);
      {acc_req, acc_instr, acc_va, acc_size} = {1'b1, ins, v, sz};
      @(negedge clk);
      acc_req = 0;
      fetched = 0;
      kind = -1;
      for (n = 0; n < 60 && kind < 0; n = n + 1) begin
        if (mem_req_r) {fetched, addr} = {1'b1, mem_addr_r};
        if (acc_abort_r) kind = 1;
        else if (walk_l2_r) {kind, wd} = {32'd2, walk_desc_r};
        else if (acc_done_r) kind = 0;
        if (kind < 0) @(negedge clk);
      end
      if (kind < 0) begin
        mismatches = mismatches + 1;
        report_and_stop;
      end
      repeat (3) @(negedge clk);
    end
  endtask
  function [31:0] rmask(input integer k);
    case (k)
      0: rmask = 32'h0000_0303;
      1: rmask = 32'hffff_c000;
      3: rmask = 32'h0000_00ff;
      6, 7: rmask = 32'hfff0_0001;
      default: rmask = 32'hffff_ffff;
    endcase
  endfunction
  initial begin
    got = $urandom(59395);
    repeat (12) @(negedge clk);
    reset = 0;
    // registers: write all, then read all so the two lockdown copies are told apart
    for (i = 0; i < 8; i = i + 1) begin
      wr_val[i] = $urandom;
      cp_write(32'haa86_5321 >> (4 * i), i == 7, wr_val[i]);
    end
    for (i = 0; i < 8; i = i + 1) begin
      cp_read(32'haa86_5321 >> (4 * i), i == 7);
      if (i == 5) `CHK(got, 32'h0000_0000)
      else `CHK(got & rmask(i), wr_val[i] & rmask(i))
      $display("register read %0d done", i);
    end
    translation_table_base = $urandom;
    cp_write(2, 0, translation_table_base);
    cp_read(2, 0);
    `CHK(got, translation_table_base & 32'hffff_c000)
    cp_write(10, 1, 32'hfff0_0001);
    cp_write(10, 0, 32'h0000_0000);
    cp_read(10, 1);
    `CHK(got, 32'hfff0_0001)
    cp_write(1, 0, 32'h0000_0000);
    va = $urandom & 32'hffff_fffc;
    access(0, va, 0, 2);
    `CHK({kind, fetched, acc_pa_r}, {32'd0, 32'd0, va})
    $display("test mmu off done");
    cp_write(1, 0, 32'h0000_0003);
    cp_write(8, 0, 32'h0000_0000);
    for (i = 0; i < 4; i = i + 1) begin
      va = ($urandom & 32'hffcf_fffc) | (i << 20);
      dsc = ($urandom & 32'hffff_fffc) | i;
      access(0, va, dsc, 2);
      `CHK(addr, {translation_table_base[31:14], va[31:20], 2'b00})
      `CHK(kind, (i == 2) ? 0 : (i == 0) ? 1 : 2)
      if (i[0]) `CHK(wd, dsc)
      if (i == 2) `CHK(acc_pa_r, {dsc[31:20], va[19:0]})
      if (i == 0) begin
        cp_read(5, 0);
        `CHK(got[7:0], {dsc[8:5], 4'h5})
        cp_read(6, 0);
        `CHK(got, va)
      end
      $display("test descriptor type %0d done", i);
    end
    access(1, {va[31:22], 2'b01, va[19:0]}, dsc, 2);
    `CHK(addr, {translation_table_base[31:14], va[31:22], 2'b01, 2'b00})
    va = ($urandom & 32'hffcf_fffc) | (2 << 20);
    dsc = ($urandom & 32'hffff_fffc) | 2;
    access(0, va, dsc, 2);
    access(0, va, 2, 2);
    `CHK({kind, fetched}, {32'd0, 32'd0})
    `CHK(acc_pa_r, {dsc[31:20], va[19:0]})
    access(1, va, 2, 2);
    `CHK(fetched, 1)
    cp_write(8, 0, 32'h0000_0000);
    access(0, va, 2, 2);
    `CHK(fetched, 1)
    access(0, va | 32'h0000_0001, 2, 2);
    cp_read(5, 0);
    `CHK({kind, got[3:0]}, {32'd1, 4'h1})
    $display("test tlb and alignment done");
    cp_write(10, 0, 32'h0000_0001);
    va = va ^ 32'h8000_0000;
    access(0, va, 2, 2);
    cp_write(8, 0, 32'h0000_0000);
    access(0, va, 2, 2);
    `CHK(fetched, 0)
    cp_read(10, 0);
    `CHK(got, 32'h0010_0001)
    $display("test lockdown done");
    report_and_stop;
  end
endmodule
